//--- rtl/pss_pkg.sv
// constants, types and register layout for the phy status register bank
package pss_pkg;
	// management register addresses
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STAT = 5'h01;
	// control register field positions
	localparam int CTRL_LOOP_BIT = 14;
	localparam int CTRL_COLT_BIT = 7;
	// status register field positions
	localparam int STAT_T4_BIT = 15;
	localparam int STAT_OVR_HI = 14;
	localparam int STAT_OVR_LO = 6;
	localparam int STAT_ANC_BIT = 5;
	localparam int STAT_RF_BIT = 4;
	localparam int STAT_ANA_BIT = 3;
	localparam int STAT_LINK_BIT = 2;
	localparam int STAT_JAB_BIT = 1;
	localparam int STAT_EXT_BIT = 0;
	// reset values
	localparam logic [15:0] STAT_RESET = 16'h7809;
	localparam logic [8:0] OVR_RESET = 9'h1E0;
	localparam logic CTRL_LOOP_RESET = 1'h0;
	localparam logic CTRL_COLT_RESET = 1'h0;
	// management frame fields
	localparam logic [4:0] PRE_ONES = 5'h1F;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [4:0] LAST_ADR_BIT = 5'h09;
	localparam logic [4:0] LAST_DATA_BIT = 5'h0F;
	// collision test timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int BIT_TIME_PS = 10000;
	localparam int COL_ON_BITS = 512;
	localparam int COL_OFF_BITS = 4;
	localparam int COL_ON_CYC = (COL_ON_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;
	localparam int COL_OFF_CYC = (COL_OFF_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;
	// management frame receiver states, gray along the frame
	typedef enum logic [2:0] {
		MF_PRE = 3'h0,
		MF_START = 3'h1,
		MF_CMD = 3'h3,
		MF_ADR = 3'h2,
		MF_TURN = 3'h6,
		MF_DATA = 3'h7
	} pss_mf_state_t;
endpackage

//--- rtl/pss_col_if.sv
// carrier between the register bank and the collision test unit
`timescale 1ns/1ps
`default_nettype none
interface pss_col_if;
	logic col_test;
	logic loopback;
	logic txen;
	logic col_det;
	logic col;
	modport unit (input col_test, input loopback, input txen, input col_det, output col);
	modport ctrl (output col_test, output loopback, output txen, output col_det, input col);
endinterface
`default_nettype wire

//--- rtl/pss_col_test.sv
// collision output steering with the collision test function
`timescale 1ns/1ps
`default_nettype none
module pss_col_test
	import pss_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// control and mac side signals
	pss_col_if.unit cif
);
	localparam int COL_ON_MAX = COL_ON_CYC;
	localparam int COL_OFF_MAX = COL_OFF_CYC;
	logic col;
	logic [10:0] rise_wait;

	// collision test follows txen even in loopback; loopback mutes real detection
	// test wins over loopback
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			col <= 1'h0;
		end else if (cif.col_test) begin
			col <= cif.txen;
		end else begin
			col <= cif.col_det & ~cif.loopback;
		end
	end
	assign cif.col = col;

	a_col_no_test: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(!cif.col_test && !cif.col_det) |=> !col)
		else $error("collision raised without detection outside test");
	a_col_loop_test: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(cif.col_test && cif.loopback && cif.txen) |=> col)
		else $error("collision test blocked by loopback");
	// cycles that a test mode txen has waited for collision; too long for a delay range
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rise_wait <= 11'h000;
		end else if (!(cif.col_test && cif.txen) || col) begin
			rise_wait <= 11'h000;
		end else if (rise_wait != 11'h7FF) begin
			rise_wait <= rise_wait + 11'h001;
		end
	end

	a_col_rise_time: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		rise_wait < 11'(COL_ON_MAX))
		else $error("collision not raised in time after txen");
	a_col_fall_time: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(cif.col_test && $fell(cif.txen)) |-> ##[1:COL_OFF_MAX] (!col || !cif.col_test || cif.txen))
		else $error("collision not dropped in time after txen");
endmodule
`default_nettype wire

//--- rtl/pss_latch.sv
// one latching status bit, latch high or latch low by parameter
`timescale 1ns/1ps
`default_nettype none
module pss_latch #(
	parameter logic ACT = 1'h1
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// condition and read clear
	input wire logic cond_i,
	input wire logic rd_clr_i,
	output logic q_o
);
	// event holds until read, then tracks condition; event beats clear
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q_o <= 1'h0;
		end else if (cond_i == ACT) begin
			q_o <= ACT;
		end else if (rd_clr_i) begin
			q_o <= cond_i;
		end
	end

	a_latch_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(q_o == ACT && !rd_clr_i) |=> (q_o == ACT))
		else $error("latched status bit lost before read");
endmodule
`default_nettype wire

//--- rtl/pss_phy_status.sv
// phy control/status management registers behind the serial management port
`timescale 1ns/1ps
`default_nettype none

module pss_phy_status
	import pss_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// serial management port
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_n_o,
	input wire logic [4:0] phy_addr_i,
	input wire logic override_en_i,
	// mac side collision path
	input wire logic txen_i,
	input wire logic col_det_i,
	output logic col_o,
	output logic loopback_o,
	// status sources
	input wire logic an_done_i,
	input wire logic rf_event_i,
	input wire logic link_ok_i,
	input wire logic jabber_i
);
	pss_mf_state_t state;
	logic mdc_q;
	logic mdc_rise;
	logic mdc_fall;
	logic [4:0] cnt;
	logic [4:0] ones;
	logic [1:0] op;
	logic [9:0] adr;
	logic [15:0] wsh;
	logic [9:0] next_adr;
	logic [15:0] next_wsh;
	logic hit;
	logic [15:0] rd_word;
	logic rd_clr;
	logic drive;
	logic dout;
	logic loopback;
	logic col_test;
	logic [8:0] ovr;
	logic anc_q;
	logic rf_q;
	logic link_q;
	logic jab_q;
	logic [15:0] stat_word;
	logic [15:0] ctrl_word;
	logic preamble_supp;

	pss_col_if cif ();

	// mdc edge detection, pins are synchronous to mclk
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mdc_q <= 1'h0;
		end else begin
			mdc_q <= mdc_i;
		end
	end
	assign mdc_rise = mdc_i & ~mdc_q;
	assign mdc_fall = ~mdc_i & mdc_q;
	assign next_adr = {adr[8:0], mdio_i};
	assign next_wsh = {wsh[14:0], mdio_i};

	// suppression bit relaxes the preamble need
	assign preamble_supp = ovr[STAT_OVR_LO - STAT_OVR_LO];

	always_comb begin
		ctrl_word = 16'h0000;
		ctrl_word[CTRL_LOOP_BIT] = loopback;
		ctrl_word[CTRL_COLT_BIT] = col_test;
	end

	// status word assembled from fixed, override and latched bits
	always_comb begin
		stat_word = 16'h0000;
		stat_word[STAT_T4_BIT] = 1'h0;
		// abilities, reserved and suppression from override bits
		stat_word[STAT_OVR_HI:STAT_OVR_LO] = ovr;
		stat_word[STAT_ANC_BIT] = anc_q;
		stat_word[STAT_RF_BIT] = rf_q;
		stat_word[STAT_ANA_BIT] = STAT_RESET[STAT_ANA_BIT];
		stat_word[STAT_LINK_BIT] = link_q;
		stat_word[STAT_JAB_BIT] = jab_q;
		stat_word[STAT_EXT_BIT] = STAT_RESET[STAT_EXT_BIT];
	end

	// management frame receiver, stepped on mdc rising edges
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= MF_PRE;
			cnt <= 5'h00;
			ones <= 5'h00;
			op <= 2'h0;
			adr <= 10'h000;
			wsh <= 16'h0000;
		end else if (mdc_rise) begin
			unique case (state)
				MF_PRE: begin
					if (mdio_i) begin
						if (ones != PRE_ONES) begin
							ones <= ones + 5'h01;
						end
					end else begin
						// start bit honoured after full preamble or when suppressed
						if (ones == PRE_ONES || preamble_supp) begin
							state <= MF_START;
						end
						ones <= 5'h00;
					end
				end
				MF_START: begin
					state <= mdio_i ? MF_CMD : MF_PRE;
					cnt <= 5'h00;
				end
				MF_CMD: begin
					op <= {op[0], mdio_i};
					cnt <= cnt + 5'h01;
					if (cnt == 5'h01) begin
						state <= MF_ADR;
						cnt <= 5'h00;
					end
				end
				MF_ADR: begin
					adr <= next_adr;
					cnt <= cnt + 5'h01;
					if (cnt == LAST_ADR_BIT) begin
						state <= MF_TURN;
						cnt <= 5'h00;
					end
				end
				MF_TURN: begin
					cnt <= cnt + 5'h01;
					if (cnt == 5'h01) begin
						state <= MF_DATA;
						cnt <= 5'h00;
					end
				end
				MF_DATA: begin
					wsh <= next_wsh;
					cnt <= cnt + 5'h01;
					if (cnt == LAST_DATA_BIT) begin
						state <= MF_PRE;
						cnt <= 5'h00;
					end
				end
				default: begin
					state <= MF_PRE;
				end
			endcase
		end
	end

	// address match, captured as the last address bit arrives
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hit <= 1'h0;
		end else if (mdc_rise && state == MF_ADR && cnt == LAST_ADR_BIT) begin
			hit <= (next_adr[9:5] == phy_addr_i);
		end
	end

	// read snapshot and read-clear pulse for the latched status bits
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_word <= 16'h0000;
			rd_clr <= 1'h0;
		end else begin
			rd_clr <= 1'h0;
			if (mdc_rise && state == MF_ADR && cnt == LAST_ADR_BIT && op == OP_READ) begin
				if (next_adr[4:0] == REG_STAT) begin
					rd_word <= stat_word;
					rd_clr <= (next_adr[9:5] == phy_addr_i);
				end else if (next_adr[4:0] == REG_CTRL) begin
					rd_word <= ctrl_word;
				end else begin
					rd_word <= 16'h0000;
				end
			end
		end
	end

	// read data driven on mdc falling edges, zero in second turnaround bit
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			drive <= 1'h0;
			dout <= 1'h0;
		end else if (mdc_fall) begin
			drive <= hit && op == OP_READ &&
				((state == MF_TURN && cnt == 5'h01) || state == MF_DATA);
			dout <= (state == MF_DATA) ? rd_word[4'hF - cnt[3:0]] : 1'h0;
		end
	end
	assign mdio_o = dout;
	assign mdio_oe_n_o = ~drive;

	// control register writes: loopback and collision test only
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			loopback <= CTRL_LOOP_RESET;
			col_test <= CTRL_COLT_RESET;
		end else if (mdc_rise && state == MF_DATA && cnt == LAST_DATA_BIT &&
			hit && op == OP_WRITE && adr[4:0] == REG_CTRL) begin
			loopback <= next_wsh[CTRL_LOOP_BIT];
			col_test <= next_wsh[CTRL_COLT_BIT];
		end
	end

	// override writable status bits 14..6; all other status bits ignore writes
	// gated by override enable
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ovr <= OVR_RESET;
		end else if (mdc_rise && state == MF_DATA && cnt == LAST_DATA_BIT &&
			hit && op == OP_WRITE && adr[4:0] == REG_STAT && override_en_i) begin
			// reserved bits stored like the others
			ovr <= next_wsh[STAT_OVR_HI:STAT_OVR_LO];
		end
	end

	pss_latch #(.ACT(1'h1)) u_anc (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.cond_i(an_done_i),
		.rd_clr_i(rd_clr),
		.q_o(anc_q)
	);
	pss_latch #(.ACT(1'h1)) u_rf (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.cond_i(rf_event_i),
		.rd_clr_i(rd_clr),
		.q_o(rf_q)
	);
	pss_latch #(.ACT(1'h0)) u_link (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.cond_i(link_ok_i),
		.rd_clr_i(rd_clr),
		.q_o(link_q)
	);
	pss_latch #(.ACT(1'h1)) u_jab (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.cond_i(jabber_i),
		.rd_clr_i(rd_clr),
		.q_o(jab_q)
	);

	// collision test unit hookup
	assign cif.col_test = col_test;
	assign cif.loopback = loopback;
	assign cif.txen = txen_i;
	assign cif.col_det = col_det_i;
	assign col_o = cif.col;
	assign loopback_o = loopback;

	pss_col_test u_col (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.cif(cif)
	);

	a_stat_t4_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		stat_word[STAT_T4_BIT] == 1'h0)
		else $error("four pair bit reads one");
	a_stat_fixed_one: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		stat_word[STAT_ANA_BIT] && stat_word[STAT_EXT_BIT])
		else $error("fixed capability bit reads zero");
	a_ctrl_rsv_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		ctrl_word[6:0] == 7'h00)
		else $error("reserved control bits not zero");
	a_ovr_locked: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!override_en_i |=> $stable(ovr))
		else $error("override bits changed while override disabled");
	a_anc_latched: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(an_done_i && !rd_clr) |=> stat_word[STAT_ANC_BIT])
		else $error("auto-negotiation complete not latched");
	a_link_low_held: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(!link_ok_i ##1 (link_ok_i && !rd_clr)[*2]) |-> !stat_word[STAT_LINK_BIT])
		else $error("link drop not held until read");
endmodule
`default_nettype wire

//--- tb/pss_sta_model.sv
// station management model: drives the management clock and data line
`timescale 1ns/1ps
`default_nettype none
module pss_sta_model
	import pss_pkg::*;
(
	// clock
	input wire logic mclk_i,
	// management line, released means pulled up by the bench
	output logic mdc_o,
	output logic drv_en_o,
	output logic drv_d_o,
	input wire logic line_i
);
	// idle: clock still and line released
	initial begin
		mdc_o = 1'h0;
		drv_en_o = 1'h0;
		drv_d_o = 1'h1;
	end

	// one bit: three mclk low, sample the line, then three mclk high
	task automatic bit_cyc(input logic en, input logic d, output logic s);
		@(negedge mclk_i);
		mdc_o = 1'h0;
		drv_en_o = en;
		drv_d_o = d;
		repeat (3) @(negedge mclk_i);
		s = line_i;
		mdc_o = 1'h1;
		repeat (2) @(negedge mclk_i);
	endtask

	// whole frame; a read lets go of the line from the turnaround on
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, input int pre, output logic [15:0] rd);
		logic s;
		logic [13:0] hdr;
		hdr = {2'h1, op, pa, ra};
		for (int i = 0; i < pre; i++) bit_cyc(1'h1, 1'h1, s);
		for (int i = 13; i >= 0; i--) bit_cyc(1'h1, hdr[i], s);
		bit_cyc(op == OP_WRITE, 1'h1, s);
		bit_cyc(op == OP_WRITE, 1'h0, s);
		for (int i = 15; i >= 0; i--) begin
			bit_cyc(op == OP_WRITE, wd[i], s);
			rd[i] = s;
		end
		@(negedge mclk_i);
		mdc_o = 1'h0;
		drv_en_o = 1'h0;
	endtask
endmodule
`default_nettype wire

//--- tb/pss_phy_status_bench.sv
// self-checking bench for the phy status and collision test registers
`timescale 1ns/1ps
`default_nettype none
module pss_phy_status_bench
	import pss_pkg::*;
;
	logic mclk = 1'h0;
	logic resetn = 1'h0;
	logic [4:0] phy_addr = 5'h05;
	logic ovr_en = 1'h0;
	logic txen = 1'h0;
	logic col_det = 1'h0;
	logic an_done = 1'h0;
	logic rf_ev = 1'h0;
	logic link_ok = 1'h1;
	logic jabber = 1'h0;
	logic mdc, drv_en, drv_d, mdio_o, oe_n, col, lb;
	wire mdio_line;
	int bad_count = 0;
	int checks_done = 0;

	// clock and wired line with pull-up
	always #2 mclk = ~mclk;
	assign mdio_line = !oe_n ? mdio_o : (drv_en ? drv_d : 1'h1);

	pss_phy_status pss_phy_status_inst (.mclk_i(mclk), .resetn_i(resetn), .mdc_i(mdc),
		.mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe_n_o(oe_n), .phy_addr_i(phy_addr),
		.override_en_i(ovr_en), .txen_i(txen), .col_det_i(col_det), .col_o(col),
		.loopback_o(lb), .an_done_i(an_done), .rf_event_i(rf_ev), .link_ok_i(link_ok),
		.jabber_i(jabber));
	pss_sta_model pss_sta_model_inst (.mclk_i(mclk), .mdc_o(mdc), .drv_en_o(drv_en),
		.drv_d_o(drv_d), .line_i(mdio_line));

	// compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// status word from override field and {anc, rf, link, jabber}
	function automatic logic [15:0] exp_stat(input logic [8:0] ovr, input logic [3:0] ev);
		return {1'h0, ovr, ev[3:2], 1'h1, ev[1:0], 1'h1};
	endfunction

	task automatic rd(input logic [4:0] ra, input int pre, output logic [15:0] v);
		pss_sta_model_inst.frame(OP_READ, phy_addr, ra, 16'h0000, pre, v);
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] v, input int pre);
		logic [15:0] d;
		pss_sta_model_inst.frame(OP_WRITE, phy_addr, ra, v, pre, d);
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// watchdog well above the expected run length
	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		report_and_stop();
	end

	// main sequence
	initial begin
		logic [15:0] v;
		logic [4:0] r;
		void'($urandom(32'h92E4F3E2));
		phy_addr = 5'($urandom);
		repeat (2) @(negedge mclk);
		resetn = 1'h1;
		rd(REG_STAT, 32, v);
		check("stat reset", v, STAT_RESET);
		rd(REG_STAT, 32, v);
		check("link tracks", v, exp_stat(OVR_RESET, 4'h2));
		rd(REG_CTRL, 32, v);
		check("ctrl reset", v, 16'h0000);
		$display("reset values done");
		// writes with override off are dropped, on they reach the override field
		wr(REG_STAT, 16'hFFFF, 32);
		rd(REG_STAT, 32, v);
		check("stat locked", v, exp_stat(OVR_RESET, 4'h2));
		ovr_en = 1'h1;
		wr(REG_STAT, 16'hFFFF, 32);
		rd(REG_STAT, 32, v);
		check("stat all ones", v, exp_stat(9'h1FF, 4'h2));
		repeat (4) begin
			r = 5'($urandom);
			wr(REG_STAT, {1'h0, r[3:0], 4'h0, r[4], 6'h09}, 32);
			rd(REG_STAT, 32, v);
			check("stat random", v, exp_stat({r[3:0], 4'h0, r[4]}, 4'h2));
		end
		$display("override writes done");
		// frame without preamble ignored until suppression is set
		wr(REG_STAT, STAT_RESET, 32);
		rd(REG_STAT, 0, v);
		check("no preamble", v, 16'hFFFF);
		wr(REG_STAT, 16'h7849, 32);
		rd(REG_STAT, 0, v);
		check("suppressed 1", v, exp_stat(9'h1E1, 4'h2));
		rd(REG_STAT, 0, v);
		check("suppressed 2", v, exp_stat(9'h1E1, 4'h2));
		wr(REG_STAT, STAT_RESET, 0);
		$display("preamble suppression done");
		// pulse every event, then read twice
		an_done = 1'h1;
		rf_ev = 1'h1;
		jabber = 1'h1;
		link_ok = 1'h0;
		repeat (3) @(negedge mclk);
		an_done = 1'h0;
		rf_ev = 1'h0;
		jabber = 1'h0;
		link_ok = 1'h1;
		rd(REG_STAT, 32, v);
		check("latched", v, exp_stat(OVR_RESET, 4'hD));
		rd(REG_STAT, 32, v);
		check("after clear", v, exp_stat(OVR_RESET, 4'h2));
		$display("latched bits done");
		// reserved control bits read zero
		wr(REG_CTRL, 16'hFFFF, 32);
		rd(REG_CTRL, 32, v);
		check("ctrl ones", v, 16'h4080);
		// frames for another address are neither answered nor applied
		pss_sta_model_inst.frame(OP_WRITE, ~phy_addr, REG_CTRL, 16'h0000, 32, v);
		pss_sta_model_inst.frame(OP_READ, ~phy_addr, REG_CTRL, 16'h0000, 32, v);
		check("other address", v, 16'hFFFF);
		rd(REG_CTRL, 32, v);
		check("ctrl kept", v, 16'h4080);
		// every loopback and collision test mode with random mac side inputs
		for (int m = 0; m < 4; m++) begin
			wr(REG_CTRL, {1'h0, m[1], 6'h00, m[0], 7'h00}, 32);
			check("loopback", 16'(lb), 16'(m[1]));
			repeat (8) begin
				txen = 1'($urandom);
				col_det = 1'($urandom);
				repeat (2) @(negedge mclk);
				check("col", 16'(col), 16'(m[0] ? txen : col_det & !m[1]));
			end
		end
		$display("collision test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
